// ===== tdl_cfg.svh
// Constants for the tamper detect enable logic
`ifndef TDL_CFG_SVH
`define TDL_CFG_SVH
`define TDL_GPR_WIDTH   32
`define TDL_ENABLE_BIT  16
`define TDL_GPR_RESET   32'h0000_0000
`define TDL_SYNC_STAGES 2
`endif

// ===== tdl_pkg.sv
// Types for the tamper detect enable logic
package tdl_pkg;
  typedef logic [31:0] tdl_word_t;
endpackage

// ===== tdl_sync.sv
// Two-flop synchroniser for one asynchronous level
module tdl_sync
  import tdl_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// ===== tdl_top.sv
// Tamper detect enable and violation logic with the pin's GPIO path
`include "tdl_cfg.svh"
module tdl_top
  import tdl_pkg::*;
(
  input  wire logic      i_mclk,
  input  wire logic      i_resetn,
  input  wire logic      i_tamper_input_pin,
  input  wire logic      i_gpr_wr,
  input  wire tdl_word_t i_gpr_wdata,
  input  wire logic      i_gpio_irq_en,
  input  wire logic      i_gpio_irq_clr,
  output tdl_word_t      o_general_purpose_reg,
  output logic           o_pin_state_reg,
  output logic           o_gpio_irq,
  output logic           o_security_violation
);
  logic tamper_sync;
  logic tamper_enable;
  logic pin_prev;
  logic violation;
  logic irq_pend;
  tdl_word_t gpr_low;

  tdl_sync u_sync (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  (i_tamper_input_pin),
    .o_sync   (tamper_sync)
  );

  wire       set_enable = i_gpr_wr && i_gpr_wdata[`TDL_ENABLE_BIT];
  wire       next_enable = tamper_enable | set_enable;
  wire       rise = tamper_sync && !pin_prev;
  wire       next_irq = (irq_pend && !i_gpio_irq_clr) || (rise && i_gpio_irq_en);
  wire       next_violation = tamper_enable && tamper_sync;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      tamper_enable <= 1'b0;
      pin_prev      <= 1'b0;
      violation     <= 1'b0;
      irq_pend      <= 1'b0;
      gpr_low       <= `TDL_GPR_RESET;
    end else begin
      tamper_enable <= next_enable;
      pin_prev      <= tamper_sync;
      violation     <= next_violation;
      irq_pend      <= next_irq;
      if (i_gpr_wr) begin
        gpr_low <= i_gpr_wdata;
      end
    end
  end

  // Bit 16 reflects the sticky enable, other bits plain storage
  always_comb begin
    o_general_purpose_reg = gpr_low;
    o_general_purpose_reg[`TDL_ENABLE_BIT] = tamper_enable;
  end
  assign o_pin_state_reg      = pin_prev;
  assign o_gpio_irq           = irq_pend;
  assign o_security_violation = violation;

  sequence enable_set_s;
    tamper_enable;
  endsequence

  enable_sticky_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    enable_set_s |=> tamper_enable)
    else $error("tamper enable cleared without reset");
  enable_reset_a : assert property (@(posedge i_mclk)
    !i_resetn |=> !tamper_enable)
    else $error("tamper enable not cleared by reset");
  enable_write_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    set_enable |=> o_general_purpose_reg[16])
    else $error("write to bit 16 did not set enable");
  violation_fire_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    tamper_enable && i_tamper_input_pin |-> ##3 o_security_violation)
    else $error("tamper not reported while enabled");
  violation_quiet_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_security_violation |-> $past(tamper_enable) && $past(tamper_sync))
    else $error("violation without enabled tamper");
  sync_delay_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $rose(tamper_sync) |-> $past(i_tamper_input_pin, 2))
    else $error("tamper sync bypassed two stages");
  psr_track_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    ##1 o_pin_state_reg == $past(tamper_sync))
    else $error("pin state not tracking pin");
  irq_raise_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    rise && i_gpio_irq_en |=> o_gpio_irq)
    else $error("pin edge did not raise gpio interrupt");

  // Clearing write aimed at the enable, with bit 16 written as zero
  sequence clear_write_s;
    i_gpr_wr && !i_gpr_wdata[`TDL_ENABLE_BIT];
  endsequence

  // Enable already set when the clearing write arrives
  sequence armed_clear_s;
    enable_set_s ##0 clear_write_s;
  endsequence

  enable_keep_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    armed_clear_s |=> o_general_purpose_reg[16])
    else $error("clearing write dropped the tamper enable");
  violation_off_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !tamper_enable |=> !o_security_violation)
    else $error("violation raised while tamper enable clear");
  irq_clear_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_gpio_irq_clr && !(rise && i_gpio_irq_en) |=> !o_gpio_irq)
    else $error("gpio interrupt not cleared");
  irq_set_wins_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    rise && i_gpio_irq_en && i_gpio_irq_clr |=> o_gpio_irq)
    else $error("clear beat a new pin edge");
  gpr_store_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_gpr_wr |=> o_general_purpose_reg[15:0] == $past(i_gpr_wdata[15:0]))
    else $error("general purpose reg low half not stored");
  irq_quiet_a : assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !o_gpio_irq && !(rise && i_gpio_irq_en) |=> !o_gpio_irq)
    else $error("gpio interrupt without enabled pin edge");
endmodule

// ===== tdl_sensor.sv
// Board tamper sensor model driving the pin
module tdl_sensor (
  input  wire logic i_mclk,
  input  wire logic i_trip,
  output logic      o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lands off the clock edge, as an unsynchronised board level would
  assign #3 o_pin = i_trip;
endmodule

// ===== tb_top.sv
// Self-checking bench for the tamper detect enable logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tdl_pkg::*;
  logic i_mclk = 0, i_resetn = 0, trip = 0, wr = 0, ien = 0, clr = 0;
  logic pin, ps, irq, viol;
  tdl_word_t wd = '0, general_purpose_reg, q_exp[$];
  int n_fail = 0, check_count = 0, cyc = 0, q_sel[$];
  string nm[4] = '{"gpr", "violation", "pin_state", "irq"};
  event ev;
  always #10 i_mclk = ~i_mclk;
  tdl_sensor sen (.i_mclk(i_mclk), .i_trip(trip), .o_pin(pin));
  tdl_top uut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_tamper_input_pin(pin),
    .i_gpr_wr(wr), .i_gpr_wdata(wd), .i_gpio_irq_en(ien), .i_gpio_irq_clr(clr),
    .o_general_purpose_reg(general_purpose_reg), .o_pin_state_reg(ps), .o_gpio_irq(irq),
    .o_security_violation(viol));
  task automatic step(int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic note(int s, tdl_word_t e);
    q_sel.push_back(s);
    q_exp.push_back(e);
    ->ev;
    #1;
  endtask
  task automatic write(tdl_word_t d);
    wd = d;
    wr = 1;
    step(1);
    wr = 0;
  endtask
  task automatic compare(int s, tdl_word_t e);
    tdl_word_t v;
    v = (s == 0) ? general_purpose_reg : {31'h0, (s == 1) ? viol : (s == 2) ? ps : irq};
    check_count++;
    if (v !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm[s], e, v);
    end
  endtask
  always @(ev) compare(q_sel.pop_front(), q_exp.pop_front());
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge i_mclk) if (++cyc == 500) begin
    n_fail++;
    print_verdict;
  end
  initial begin
    wd = $urandom(32'h0000_37c9);
    wd = '0;
    step(10);
    i_resetn = 1;
    note(0, 32'h0000_0000);
    trip = 1;
    step(4);
    note(1, 32'h0000_0000);
    note(2, 32'h0000_0001);
    note(3, 32'h0000_0000);
    $display("test 1 done");
    trip = 0;
    step(4);
    write($urandom | 32'h0001_0000);
    note(0, wd);
    trip = 1;
    step(2);
    note(1, 32'h0000_0000);
    step(1);
    note(1, 32'h0000_0001);
    $display("test 2 done");
    write($urandom & 32'hfffe_ffff);
    note(0, wd | 32'h0001_0000);
    trip = 0;
    ien = 1;
    step(4);
    trip = 1;
    step(4);
    note(3, 32'h0000_0001);
    clr = 1;
    step(1);
    clr = 0;
    note(3, 32'h0000_0000);
    $display("test 3 done");
    i_resetn = 0;
    step(2);
    i_resetn = 1;
    step(4);
    note(0, 32'h0000_0000);
    note(1, 32'h0000_0000);
    $display("test 4 done");
    print_verdict;
  end
endmodule
